// [rtl/tsf_defines.svh]
// Offsets, field positions, reset values for the status flag block.
// Assumes an APB slave with byte addresses equal to four times the index.
`ifndef TSF_DEFINES_SVH
`define TSF_DEFINES_SVH

// ----------------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------------
`define TSF_IDX_STATUS 6'h00
`define TSF_IDX_ENABLE 6'h01
`define TSF_IDX_FIFO_DATA 6'h08
`define TSF_IDX_CONTROL 6'h0A

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define TSF_BIT_AFULL 7
`define TSF_BIT_LOW 2
`define TSF_BIT_HIGH 1
`define TSF_BIT_RDY 0
`define TSF_BIT_FIFO_CLR 4
`define TSF_BIT_PIN_IRQ 0

// ----------------------------------------------------------------------
// Masks and reset values
// ----------------------------------------------------------------------
`define TSF_FLAG_MASK 8'h87
`define TSF_CTRL_MASK 8'h11
`define TSF_FLAGS_RST 8'h00
`define TSF_ENABLE_RST 8'h00
`define TSF_CTRL_RST 8'h00

`endif

// [rtl/tsf_pkg.sv]
// Types shared by the status flag block.
// Assumes tsf_defines.svh is available on the include path.
package tsf_pkg;

    // ------------------------------------------------------------------
    // Data types
    // ------------------------------------------------------------------
    typedef logic [7:0] tsf_byte_t;
    typedef logic [15:0] tsf_temp_t;

    // Register selected by the APB address
    typedef enum logic [2:0] {
        TSF_SEL_NONE,
        TSF_SEL_STATUS,
        TSF_SEL_ENABLE,
        TSF_SEL_FIFO,
        TSF_SEL_CONTROL
    } tsf_sel_t;

endpackage : tsf_pkg

// [rtl/tsf_status_flags.sv]
// Status flags, interrupt enables and interrupt pin of the sensor.
// Assumes core inputs on clk; APB master keeps the bus protocol.
//
// Behaviour
// - Almost-full flag bit 7, cleared by status read
// - Fifo data read clears almost-full when enabled
// - Low alarm set when result below limit
// - Enabled low alarm drives pin interrupt
// - Status read clears low alarm
// - High alarm set when result above limit
// - Enabled high alarm drives pin interrupt
// - Status read clears high alarm
// - Ready flag set when conversion completes
// - Enabled ready flag drives pin interrupt
// - Status or fifo read clears ready
// - Enable bit 7 gates almost-full interrupt
// - All interrupt enables reset to zero
`timescale 1ns/1ns
`include "tsf_defines.svh"

module tsf_status_flags (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Sensor core
    input wire logic conv_done,
    input wire tsf_pkg::tsf_temp_t temp_result,
    input wire tsf_pkg::tsf_temp_t alarm_low_limit,
    input wire tsf_pkg::tsf_temp_t alarm_high_limit,
    input wire logic fifo_afull_event,
    input wire tsf_pkg::tsf_byte_t fifo_rd_data,
    output logic fifo_pop,
    // Multipurpose pin zero
    output logic multipurpose_pin_zero_out,
    output logic multipurpose_pin_zero_oe
);
    import tsf_pkg::*;

    // ------------------------------------------------------------------
    // Functions
    // ------------------------------------------------------------------
    function automatic logic tsf_below(input tsf_temp_t a,
                                       input tsf_temp_t b);
        tsf_below = $signed(a) < $signed(b);
    endfunction : tsf_below

    function automatic logic tsf_hit(input logic [7:0] addr,
                                     input logic [5:0] idx);
        tsf_hit = (addr[1:0] == 2'h0) && (addr[7:2] == idx);
    endfunction : tsf_hit

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    tsf_byte_t flags_q;
    tsf_byte_t flags_d;
    tsf_byte_t enable_q;
    tsf_byte_t ctrl_q;
    tsf_sel_t sel_q;
    logic [31:0] prdata_q;
    logic pready_q;
    logic pslverr_q;
    logic fifo_pop_q;
    logic irq_q;
    logic oe_q;

    // ------------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------------
    tsf_sel_t sel_w;
    logic setup_w;
    logic done_w;
    logic status_rd_w;
    logic fifo_rd_w;
    logic enable_wr_w;
    logic ctrl_wr_w;
    tsf_byte_t rdata_w;

    assign setup_w = psel & ~penable;
    assign done_w = psel & penable & pready_q;
    assign sel_w = tsf_hit(paddr, `TSF_IDX_STATUS) ? TSF_SEL_STATUS :
                   tsf_hit(paddr, `TSF_IDX_ENABLE) ? TSF_SEL_ENABLE :
                   tsf_hit(paddr, `TSF_IDX_FIFO_DATA) ? TSF_SEL_FIFO :
                   tsf_hit(paddr, `TSF_IDX_CONTROL) ? TSF_SEL_CONTROL :
                   TSF_SEL_NONE;
    assign rdata_w = (sel_w == TSF_SEL_STATUS) ? flags_q :
                     (sel_w == TSF_SEL_ENABLE) ? enable_q :
                     (sel_w == TSF_SEL_FIFO) ? fifo_rd_data :
                     (sel_w == TSF_SEL_CONTROL) ? ctrl_q : 8'h00;
    assign status_rd_w = done_w & ~pwrite & (sel_q == TSF_SEL_STATUS);
    assign fifo_rd_w = done_w & ~pwrite & (sel_q == TSF_SEL_FIFO);
    assign enable_wr_w = done_w & pwrite & (sel_q == TSF_SEL_ENABLE);
    assign ctrl_wr_w = done_w & pwrite & (sel_q == TSF_SEL_CONTROL);

    // ------------------------------------------------------------------
    // Flag set and clear terms
    // ------------------------------------------------------------------
    tsf_byte_t set_w;
    tsf_byte_t clr_w;
    tsf_byte_t snap_w;
    logic fifo_clr_en_w;
    logic low_hit_w;
    logic high_hit_w;

    assign low_hit_w = conv_done & tsf_below(temp_result, alarm_low_limit);
    assign high_hit_w = conv_done & tsf_below(alarm_high_limit, temp_result);
    assign fifo_clr_en_w = ctrl_q[`TSF_BIT_FIFO_CLR];
    assign set_w = {fifo_afull_event, 4'h0, low_hit_w, high_hit_w,
                    conv_done};
    // Only bits the host actually saw are cleared by a status read
    assign snap_w = status_rd_w ? prdata_q[7:0] : 8'h00;
    assign clr_w = snap_w |
                   {fifo_rd_w & fifo_clr_en_w, 6'h00, fifo_rd_w};
    assign flags_d = ((flags_q & ~clr_w) | set_w) & `TSF_FLAG_MASK;

    // ------------------------------------------------------------------
    // Interrupt combine
    // ------------------------------------------------------------------
    logic irq_d;

    assign irq_d = |(flags_q & enable_q) & ctrl_q[`TSF_BIT_PIN_IRQ];

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            flags_q <= `TSF_FLAGS_RST;
        end else begin
            flags_q <= flags_d;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            enable_q <= `TSF_ENABLE_RST;
        end else if (enable_wr_w) begin
            enable_q <= pwdata[7:0] & `TSF_FLAG_MASK;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_q <= `TSF_CTRL_RST;
        end else if (ctrl_wr_w) begin
            ctrl_q <= pwdata[7:0] & `TSF_CTRL_MASK;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sel_q <= TSF_SEL_NONE;
            prdata_q <= 32'h0000_0000;
            pslverr_q <= 1'b0;
        end else if (setup_w) begin
            sel_q <= sel_w;
            prdata_q <= pwrite ? 32'h0000_0000 : {24'h00_0000, rdata_w};
            pslverr_q <= (sel_w == TSF_SEL_NONE);
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pready_q <= 1'b0;
            fifo_pop_q <= 1'b0;
            irq_q <= 1'b0;
            oe_q <= 1'b0;
        end else begin
            pready_q <= setup_w;
            fifo_pop_q <= fifo_rd_w;
            irq_q <= irq_d;
            oe_q <= ctrl_q[`TSF_BIT_PIN_IRQ];
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign fifo_pop = fifo_pop_q;
    assign multipurpose_pin_zero_out = irq_q;
    assign multipurpose_pin_zero_oe = oe_q;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    chk_afull_status_clr: assert property (
        status_rd_w && prdata_q[`TSF_BIT_AFULL] && !fifo_afull_event
        |=> !flags_q[`TSF_BIT_AFULL])
        else $error("almost-full not cleared by status read");

    chk_afull_fifo_clr: assert property (
        fifo_rd_w && ctrl_q[`TSF_BIT_FIFO_CLR] && !fifo_afull_event
        |=> !flags_q[`TSF_BIT_AFULL])
        else $error("almost-full not cleared by fifo read");

    chk_afull_fifo_keep: assert property (
        fifo_rd_w && !ctrl_q[`TSF_BIT_FIFO_CLR] &&
        flags_q[`TSF_BIT_AFULL]
        |=> flags_q[`TSF_BIT_AFULL])
        else $error("almost-full cleared while setting is off");

    chk_low_set: assert property (
        conv_done && ($signed(temp_result) < $signed(alarm_low_limit))
        |=> flags_q[`TSF_BIT_LOW])
        else $error("low alarm not set");

    chk_low_irq: assert property (
        flags_q[`TSF_BIT_LOW] && enable_q[`TSF_BIT_LOW] &&
        ctrl_q[`TSF_BIT_PIN_IRQ]
        |=> multipurpose_pin_zero_out && multipurpose_pin_zero_oe)
        else $error("low alarm interrupt missing");

    chk_low_clr: assert property (
        status_rd_w && prdata_q[`TSF_BIT_LOW] && !conv_done
        |=> !flags_q[`TSF_BIT_LOW])
        else $error("low alarm not cleared by status read");

    chk_high_set: assert property (
        conv_done && ($signed(temp_result) > $signed(alarm_high_limit))
        |=> flags_q[`TSF_BIT_HIGH])
        else $error("high alarm not set");

    chk_high_irq: assert property (
        flags_q[`TSF_BIT_HIGH] && enable_q[`TSF_BIT_HIGH] &&
        ctrl_q[`TSF_BIT_PIN_IRQ]
        |=> multipurpose_pin_zero_out)
        else $error("high alarm interrupt missing");

    chk_high_clr: assert property (
        status_rd_w && prdata_q[`TSF_BIT_HIGH] && !conv_done
        |=> !flags_q[`TSF_BIT_HIGH])
        else $error("high alarm not cleared by status read");

    chk_rdy_set: assert property (
        conv_done |=> flags_q[`TSF_BIT_RDY])
        else $error("ready flag not set");

    chk_rdy_irq: assert property (
        flags_q[`TSF_BIT_RDY] && enable_q[`TSF_BIT_RDY] &&
        ctrl_q[`TSF_BIT_PIN_IRQ]
        |=> multipurpose_pin_zero_out)
        else $error("ready interrupt missing");

    chk_rdy_fifo_clr: assert property (
        fifo_rd_w && !conv_done |=> !flags_q[`TSF_BIT_RDY] && fifo_pop)
        else $error("ready not cleared by fifo read");

    chk_afull_gate: assert property (
        (flags_q & enable_q) == 8'h00 |=> !multipurpose_pin_zero_out)
        else $error("interrupt without enabled flag");

    chk_en_reset: assert property (
        $rose(rst_n) |-> enable_q == 8'h00 && !multipurpose_pin_zero_out)
        else $error("enables not zero after reset");

    chk_irq_fall: assert property (
        ctrl_q[`TSF_BIT_PIN_IRQ] && $fell(|(flags_q & enable_q))
        |=> $fell(multipurpose_pin_zero_out))
        else $error("interrupt did not deassert");

    chk_set_wins: assert property (
        status_rd_w && conv_done |=> flags_q[`TSF_BIT_RDY])
        else $error("event lost on clearing read");

    chk_rdy_status_clr: assert property (
        status_rd_w && prdata_q[`TSF_BIT_RDY] && !conv_done
        |=> !flags_q[`TSF_BIT_RDY])
        else $error("ready not cleared by status read");

    chk_pin_mode: assert property (
        !ctrl_q[`TSF_BIT_PIN_IRQ]
        |=> !multipurpose_pin_zero_out && !multipurpose_pin_zero_oe)
        else $error("pin active outside interrupt mode");

    chk_alarm_set_wins: assert property (
        status_rd_w && conv_done &&
        ($signed(temp_result) < $signed(alarm_low_limit))
        |=> flags_q[`TSF_BIT_LOW])
        else $error("low alarm lost on clearing read");

    chk_afull_set: assert property (
        fifo_afull_event |=> flags_q[`TSF_BIT_AFULL])
        else $error("almost-full not set");

    chk_status_ro: assert property (
        done_w && pwrite && (sel_q == TSF_SEL_STATUS) &&
        !fifo_afull_event && !conv_done
        |=> flags_q == $past(flags_q))
        else $error("status changed by a write");

    cov_status_clear: cover property (
        status_rd_w && prdata_q[`TSF_BIT_LOW] ##1 !flags_q[`TSF_BIT_LOW]);
    cov_irq_rise: cover property ($rose(multipurpose_pin_zero_out));
    cov_fifo_clear: cover property (
        fifo_rd_w && ctrl_q[`TSF_BIT_FIFO_CLR] && flags_q[`TSF_BIT_AFULL]);
    cov_set_clear: cover property (status_rd_w && conv_done);
    cov_pin_mode_off: cover property (
        !ctrl_q[`TSF_BIT_PIN_IRQ] && (flags_q & enable_q) != 8'h00);

endmodule : tsf_status_flags

// [tb/tsf_host_model.sv]
// APB master standing in for the host of the status flag block.
// Assumes xfer is entered just after a rising edge of clk.
`timescale 1ns/1ns
module tsf_host_model (
    // Clock
    input wire logic clk,
    // APB master side
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [7:0] paddr,
    output logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    initial begin
        psel = 1'h0;
        penable = 1'h0;
        pwrite = 1'h0;
        paddr = 8'h00;
        pwdata = 32'h0;
    end
    // ------------------------------------------------------------------
    // Transfer
    // ------------------------------------------------------------------
    // status read names source
    task automatic xfer(input logic w, input logic [7:0] a,
            input logic [31:0] wd, output logic [31:0] rd,
            output logic err);
        psel <= 1'h1;
        penable <= 1'h0;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'h1;
        @(posedge clk);
        while (pready !== 1'h1) @(posedge clk);
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        paddr <= ~a;
        pwdata <= ~wd;
    endtask : xfer
endmodule : tsf_host_model

// [tb/tb.sv]
// Self-checking bench of the status flag block.
// Assumes tsf_host_model drives the APB side of the design.
`timescale 1ns/1ns
module tb;
    import tsf_pkg::*;
    logic clk, rst_n, psel, penable, pwrite, pready, pslverr, rerr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rdat;
    logic conv_done, fifo_afull_event, fifo_pop, pin_out, pin_oe;
    tsf_temp_t temp_result, alarm_low_limit, alarm_high_limit;
    tsf_byte_t fifo_rd_data;
    int err_count = 0;
    int tests_run = 0;
    tsf_status_flags DUT (.clk(clk), .rst_n(rst_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .conv_done(conv_done), .temp_result(temp_result),
        .alarm_low_limit(alarm_low_limit),
        .alarm_high_limit(alarm_high_limit),
        .fifo_afull_event(fifo_afull_event), .fifo_rd_data(fifo_rd_data),
        .fifo_pop(fifo_pop), .multipurpose_pin_zero_out(pin_out),
        .multipurpose_pin_zero_oe(pin_oe));
    tsf_host_model host (.clk(clk), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr));
    initial begin
        clk = 1'h0;
        forever #10 clk = ~clk;
    end
    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    task automatic chk(input string n, input logic [31:0] s,
            input logic [31:0] e);
        tests_run++;
        if (s !== e) begin
            err_count++;
            $display("BAD %s exp %0h seen %0h", n, e, s);
        end
    endtask : chk
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : tally_and_finish
    task automatic acc(input logic w, input logic [7:0] a,
            input logic [31:0] wd);
        host.xfer(w, a, wd, rdat, rerr);
        @(posedge clk);
    endtask : acc
    task automatic conv(input tsf_temp_t t);
        conv_done <= 1'h1;
        temp_result <= t;
        @(posedge clk);
        conv_done <= 1'h0;
        temp_result <= ~t;
        repeat (3) @(posedge clk);
    endtask : conv
    task automatic afull();
        fifo_afull_event <= 1'h1;
        @(posedge clk);
        fifo_afull_event <= 1'h0;
        repeat (3) @(posedge clk);
    endtask : afull
    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_reset();
        chk("pin_oe", {31'h0, pin_oe}, 32'h0);
        chk("pin_out", {31'h0, pin_out}, 32'h0);
        acc(1'h0, 8'h04, 32'h0);
        chk("enable", rdat, 32'h0);
        acc(1'h0, 8'h00, 32'h0);
        chk("status", rdat, 32'h0);
    endtask : t_reset
    task automatic t_alarm();
        tsf_temp_t tv[3] = '{16'hFF00, 16'h0300, 16'h0100};
        logic [31:0] ev[3] = '{32'h5, 32'h3, 32'h1};
        acc(1'h1, 8'h28, 32'h1);
        acc(1'h1, 8'h04, 32'h7);
        for (int i = 0; i < 3; i++) begin
            conv(tv[i]);
            chk("pin_irq", {31'h0, pin_out}, 32'h1);
            chk("pin_oe", {31'h0, pin_oe}, 32'h1);
            acc(1'h0, 8'h00, 32'h0);
            chk("status_set", rdat, ev[i]);
            acc(1'h0, 8'h00, 32'h0);
            chk("status_clr", rdat, 32'h0);
            repeat (2) @(posedge clk);
            chk("pin_idle", {31'h0, pin_out}, 32'h0);
        end
        acc(1'h1, 8'h04, 32'h4);
        conv(16'h0300);
        chk("pin_masked", {31'h0, pin_out}, 32'h0);
        acc(1'h0, 8'h00, 32'h0);
        chk("status_masked", rdat, 32'h3);
    endtask : t_alarm
    task automatic t_afull();
        acc(1'h1, 8'h04, 32'h80);
        afull();
        chk("afull_pin", {31'h0, pin_out}, 32'h1);
        acc(1'h1, 8'h04, 32'h0);
        repeat (2) @(posedge clk);
        chk("afull_gated", {31'h0, pin_out}, 32'h0);
        fork
            acc(1'h0, 8'h20, 32'h0);
            begin
                repeat (2) @(posedge clk);
                @(negedge clk);
                chk("pop", {31'h0, fifo_pop}, 32'h1);
            end
        join
        chk("fifo_data", rdat, 32'hA5);
        acc(1'h0, 8'h00, 32'h0);
        chk("afull_kept", rdat, 32'h80);
        acc(1'h0, 8'h00, 32'h0);
        chk("afull_clr", rdat, 32'h0);
        acc(1'h1, 8'h28, 32'h11);
        acc(1'h0, 8'h28, 32'h0);
        chk("control", rdat, 32'h11);
        afull();
        conv(16'h0150);
        acc(1'h0, 8'h20, 32'h0);
        acc(1'h0, 8'h00, 32'h0);
        chk("fifo_clr", rdat, 32'h0);
    endtask : t_afull
    task automatic t_setwins();
        conv(16'h0150);
        fork
            acc(1'h0, 8'h00, 32'h0);
            begin
                @(posedge clk);
                conv_done <= 1'h1;
                temp_result <= 16'hFF00;
                @(posedge clk);
                conv_done <= 1'h0;
            end
        join
        chk("status_rdy", rdat, 32'h1);
        acc(1'h0, 8'h00, 32'h0);
        chk("set_wins", rdat, 32'h5);
    endtask : t_setwins
    task automatic t_refuse();
        acc(1'h0, 8'h0C, 32'h0);
        chk("unmapped_err", {31'h0, rerr}, 32'h1);
        chk("unmapped_data", rdat, 32'h0);
        acc(1'h1, 8'h05, 32'h7);
        chk("misaligned_err", {31'h0, rerr}, 32'h1);
        acc(1'h0, 8'h04, 32'h0);
        chk("enable_kept", rdat, 32'h0);
        acc(1'h1, 8'h00, 32'hFF);
        acc(1'h0, 8'h00, 32'h0);
        chk("status_ro", rdat, 32'h0);
        acc(1'h1, 8'h04, 32'h1);
        acc(1'h1, 8'h28, 32'h0);
        conv(16'h0150);
        chk("pin_mode_off", {31'h0, pin_out}, 32'h0);
        chk("pin_oe_off", {31'h0, pin_oe}, 32'h0);
        acc(1'h0, 8'h00, 32'h0);
        chk("status_mode_off", rdat, 32'h1);
    endtask : t_refuse
    initial begin
        rst_n = 1'h0;
        conv_done = 1'h0;
        fifo_afull_event = 1'h0;
        temp_result = 16'h0000;
        alarm_low_limit = 16'h0100;
        alarm_high_limit = 16'h0200;
        fifo_rd_data = 8'hA5;
        repeat (10) @(posedge clk);
        rst_n <= 1'h1;
        @(posedge clk);
        t_reset();
        t_alarm();
        t_afull();
        t_setwins();
        t_refuse();
        tally_and_finish();
    end
    initial begin
        repeat (5000) @(posedge clk);
        err_count++;
        tally_and_finish();
    end
endmodule : tb
